// ==== reset_source_manager.sv ====
/*
 * Reset source manager: merges power-on reset, the external reset pin,
 * the low-supply detector and watchdog events into the core reset, with
 * start-up delays timed on the low-speed oscillator tick. AHB-Lite slave.
 * Assumes pin and detector inputs are asynchronous; watchdog and mode
 * inputs come from logic on hclk. hresetn is the power-on reset.
 */
// Added by the designer: the AHB-Lite register port and the register offsets.
// Functional notes
// - power-on presets ports high, start at zero
// - long start-up delay after power or low-voltage
// - pin low holds; delay after release
// - pin reset clears program counter
// - low-voltage monitor on outside power-down, sets flag
// - ignore low supply shorter than minimum
// - four threshold codes are valid
// - bad code: reset, restore, set flag
// - genuine low-voltage reset keeps threshold code
// - threshold code powers up as 0x55
// - monitor disabled in power-down mode
// - low-voltage flag cleared only by writing zero
// - bad-threshold flag cleared only by writing zero
// - upper five flag bits read zero
// - normal watchdog time-out resets, sets time-out
// - short start-up delay after watchdog reset
// - sleeping time-out clears only counter, stack
// - bad watchdog code flag, write-zero clear
// - time-out, power-down flags track reset kind
`timescale 1ns/1ps
`default_nettype none

module reset_source_manager
	import reset_source_pkg::*;
#(
	parameter int unsigned LSOSC_DIV        = LSOSC_DIV_CYC,
	parameter int unsigned LONG_TICKS       = STARTUP_LONG_TICKS,
	parameter int unsigned SHORT_TICKS      = STARTUP_SHORT_TICKS,
	parameter int unsigned LOW_SUPPLY_CYC   = LOW_SUPPLY_MIN_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata,
	input  wire logic        external_reset_pin_n,
	input  wire logic        low_supply_detect,
	input  wire logic        watchdog_timeout,
	input  wire logic        bad_watchdog_code,
	input  wire logic        sleep_mode,
	input  wire logic        idle_mode,
	input  wire logic        powerdown_mode,
	output var  logic        core_reset_n,
	output var  logic        pc_clear,
	output var  logic        sp_clear,
	output var  logic        io_port_preset,
	output var  logic        timeout_status_flag,
	output var  logic        powerdown_status_flag,
	output var  logic [7:0]  threshold_select_code,
	output var  logic        low_voltage_reset_monitor_en
);

	// threshold code check, used by the invalid code checker logic
	function automatic logic code_is_valid(input logic [7:0] c);
		return (c == THR_2V10) || (c == THR_2V55) ||
		       (c == THR_3V15) || (c == THR_3V80);
	endfunction : code_is_valid

	// register offset match
	function automatic logic ofs_hit(input logic [31:0] a,
	                                 input logic [7:0]  ofs);
		return (a[31:8] == 24'h000000) && (a[7:0] == ofs);
	endfunction : ofs_hit

	logic              pin_s1_r;
	logic              pin_s2_r;
	logic              low_s1_r;
	logic              low_s2_r;
	logic [DIV_W-1:0]  div_cnt_r;
	logic              tick;
	logic [CNT_W-1:0]  low_cnt_r;
	logic              lowv_fire;
	logic              lowv_hold;
	logic [1:0]        bad_src;
	logic [1:0]        bad_fire;
	seq_state_e        state_r;
	seq_state_e        state_nxt;
	logic [CNT_W-1:0]  delay_cnt_r;
	logic [CNT_W-1:0]  delay_cnt_nxt;
	logic              sleepy;
	logic              wdt_full;
	logic              wdt_part;
	logic              full_evt;
	logic              hold_req;
	logic              load_delay;
	logic [CNT_W-1:0]  load_val;
	logic [7:0]        thresh_r;
	logic [7:0]        thresh_nxt;
	logic [FLAGS_W-1:0] flags_r;
	logic [FLAGS_W-1:0] flags_nxt;
	logic [FLAGS_W-1:0] flags_set;
	logic              to_nxt;
	logic              pdf_nxt;
	logic              addr_phase;
	logic              wr_pend_r;
	logic              rd_pend_r;
	logic [31:0]       dp_addr_r;
	logic              wr_thr;
	logic              wr_flags;
	logic              wr_stat;
	logic [31:0]       rd_data;

	// two-stage synchronisers for the pin and the supply comparator
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			low_s1_r <= 1'b0;
			low_s2_r <= 1'b0;
		end else begin
			pin_s1_r <= external_reset_pin_n;
			pin_s2_r <= pin_s1_r;
			low_s1_r <= low_supply_detect;
			low_s2_r <= low_s1_r;
		end
	end

	// low-speed oscillator tick from the bus clock
	assign tick = (div_cnt_r == DIV_W'(LSOSC_DIV - 1));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_cnt_r <= '0;
		else
			div_cnt_r <= tick ? '0 : div_cnt_r + DIV_W'(1);
	end

	// low-supply filter: fires once the low level outlasts the minimum
	assign lowv_fire = low_s2_r && low_voltage_reset_monitor_en &&
	                   (low_cnt_r == CNT_W'(LOW_SUPPLY_CYC));
	assign lowv_hold = low_s2_r && low_voltage_reset_monitor_en &&
	                   (low_cnt_r > CNT_W'(LOW_SUPPLY_CYC));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			low_cnt_r <= '0;
		else if (!(low_s2_r && low_voltage_reset_monitor_en))
			low_cnt_r <= '0;
		else if (!lowv_hold)
			low_cnt_r <= low_cnt_r + CNT_W'(1);
	end

	// invalid control code checkers: 0 threshold, 1 watchdog control
	assign bad_src[0] = !code_is_valid(thresh_r);
	assign bad_src[1] = bad_watchdog_code && (state_r == ST_RUN);
	for (genvar i = 0; i < 2; i++) begin : g_bad
		logic [1:0] tcnt_r;
		assign bad_fire[i] = bad_src[i] && tick &&
		                     (tcnt_r == BAD_CODE_TICKS - 2'h1);
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn)
				tcnt_r <= '0;
			else if (!bad_src[i])
				tcnt_r <= '0;
			else if (tick && (tcnt_r != BAD_CODE_TICKS))
				tcnt_r <= tcnt_r + 2'h1;
		end
	end

	// event classification
	assign sleepy   = sleep_mode || idle_mode;
	assign wdt_full = watchdog_timeout && !sleepy;
	assign wdt_part = watchdog_timeout && sleepy;
	assign full_evt = lowv_fire || bad_fire[0] || bad_fire[1] || wdt_full;
	assign hold_req = !pin_s2_r || lowv_hold;

	// start-up delay reload; only a lone watchdog event takes the short one
	assign load_delay = (full_evt && !hold_req) ||
	                    ((state_r == ST_HOLD) && !hold_req);
	assign load_val = (wdt_full && !lowv_fire && !bad_fire[0] &&
	                   !bad_fire[1] && (state_r != ST_HOLD)) ?
	                  CNT_W'(SHORT_TICKS) : CNT_W'(LONG_TICKS);

	// sequencer next state
	always_comb begin
		state_nxt     = state_r;
		delay_cnt_nxt = delay_cnt_r;
		if (hold_req) begin
			state_nxt = ST_HOLD;
		end else if (load_delay) begin
			state_nxt     = ST_DELAY;
			delay_cnt_nxt = load_val;
		end else begin
			case (state_r)
				ST_DELAY: begin
					if (delay_cnt_r == '0)
						state_nxt = ST_RUN;
					else if (tick)
						delay_cnt_nxt = delay_cnt_r - CNT_W'(1);
				end
				ST_RUN:   state_nxt = ST_RUN;
				default:  state_nxt = ST_DELAY;
			endcase
		end
	end

	// sequencer registers and reset outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r        <= ST_DELAY;
			delay_cnt_r    <= CNT_W'(LONG_TICKS);
			core_reset_n   <= 1'b0;
			pc_clear       <= 1'b1;
			sp_clear       <= 1'b1;
			io_port_preset <= 1'b1;
		end else begin
			state_r        <= state_nxt;
			delay_cnt_r    <= delay_cnt_nxt;
			core_reset_n   <= (state_nxt == ST_RUN);
			pc_clear       <= (state_nxt != ST_RUN) || wdt_part;
			sp_clear       <= (state_nxt != ST_RUN) || wdt_part;
			io_port_preset <= (state_nxt != ST_RUN);
		end
	end

	// monitor enable follows power-down mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			low_voltage_reset_monitor_en <= 1'b1;
		else
			low_voltage_reset_monitor_en <= !powerdown_mode;
	end

	// bus address phase capture; reads take one wait state
	assign addr_phase = hsel && htrans[1] && hready;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			dp_addr_r <= '0;
		end else begin
			wr_pend_r <= addr_phase && hwrite;
			rd_pend_r <= addr_phase && !hwrite;
			if (addr_phase)
				dp_addr_r <= haddr;
		end
	end

	// write decode and read mux
	assign wr_thr   = wr_pend_r && ofs_hit(dp_addr_r, THRESH_OFS);
	assign wr_flags = wr_pend_r && ofs_hit(dp_addr_r, FLAGS_OFS);
	assign wr_stat  = wr_pend_r && ofs_hit(dp_addr_r, STATUS_OFS);
	assign rd_data  =
		ofs_hit(dp_addr_r, THRESH_OFS) ? {24'h000000, thresh_r} :
		ofs_hit(dp_addr_r, FLAGS_OFS)  ? {29'h00000000, flags_r} :
		ofs_hit(dp_addr_r, STATUS_OFS) ?
			{30'h00000000, powerdown_status_flag, timeout_status_flag} :
			32'h00000000;

	// bus response
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= '0;
		end else begin
			hreadyout <= !(addr_phase && !hwrite);
			hresp     <= 1'b0;
			if (rd_pend_r)
				hrdata <= rd_data;
		end
	end

	// threshold code: restore beats a write, a real low-voltage keeps it
	assign thresh_nxt = bad_fire[0] ? THRESH_POR :
	                    wr_thr ? hwdata[7:0] : thresh_r;

	// cause flags: hardware set wins, software can only clear
	assign flags_set[FLAG_LOWV_BIT]   = lowv_fire;
	assign flags_set[FLAG_BADTHR_BIT] = bad_fire[0];
	assign flags_set[FLAG_BADWDT_BIT] = bad_fire[1];
	assign flags_nxt = flags_set |
	                   (wr_flags ? (flags_r & hwdata[FLAGS_W-1:0]) : flags_r);

	// time-out and power-down status, same set-wins clearing
	assign to_nxt  = watchdog_timeout || (timeout_status_flag &&
	                 !(wr_stat && !hwdata[STAT_TIMEOUT_BIT]));
	assign pdf_nxt = wdt_part || (powerdown_status_flag &&
	                 !(wr_stat && !hwdata[STAT_PWRDN_BIT]));

	// software-visible registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			thresh_r              <= THRESH_POR;
			threshold_select_code <= THRESH_POR;
			flags_r               <= '0;
			timeout_status_flag   <= 1'b0;
			powerdown_status_flag <= 1'b0;
		end else begin
			thresh_r              <= thresh_nxt;
			threshold_select_code <= thresh_nxt;
			flags_r               <= flags_nxt;
			timeout_status_flag   <= to_nxt;
			powerdown_status_flag <= pdf_nxt;
		end
	end

	// checks
	sequence s_sleep_timeout;
		watchdog_timeout && sleepy && !hold_req && !full_evt &&
		(state_r == ST_RUN);
	endsequence

	sequence s_partial_clear;
		pc_clear && sp_clear && core_reset_n &&
		timeout_status_flag && powerdown_status_flag;
	endsequence

	a_pin_holds_core: assert property (@(posedge hclk)
		disable iff (!hresetn) !pin_s2_r |=> !core_reset_n && pc_clear)
		else $error("core not held while pin low");

	a_pin_release_delay: assert property (@(posedge hclk)
		disable iff (!hresetn)
		$rose(pin_s2_r) && !lowv_hold |=> (state_r == ST_DELAY) &&
		(delay_cnt_r == CNT_W'(LONG_TICKS)) && !core_reset_n)
		else $error("pin release did not start long delay");

	a_lowv_flag_set: assert property (@(posedge hclk)
		disable iff (!hresetn)
		lowv_fire |=> flags_r[FLAG_LOWV_BIT] && !core_reset_n)
		else $error("low-voltage reset did not set flag");

	a_lowv_filter: assert property (@(posedge hclk)
		disable iff (!hresetn)
		!(low_s2_r && low_voltage_reset_monitor_en) |=>
		(low_cnt_r == '0) && !lowv_fire)
		else $error("low supply filter did not restart");

	a_bad_code_restore: assert property (@(posedge hclk)
		disable iff (!hresetn)
		bad_fire[0] |=> (thresh_r == THRESH_POR) &&
		flags_r[FLAG_BADTHR_BIT] && !core_reset_n)
		else $error("bad threshold code not handled");

	a_bad_code_delay: assert property (@(posedge hclk)
		disable iff (!hresetn) $rose(bad_src[0]) |-> !bad_fire[0] [*2])
		else $error("bad threshold code acted on at once");

	a_lowv_keeps_code: assert property (@(posedge hclk)
		disable iff (!hresetn)
		lowv_fire && !bad_fire[0] && !wr_thr |=> $stable(thresh_r))
		else $error("threshold code changed by low-voltage reset");

	a_monitor_off_pd: assert property (@(posedge hclk)
		disable iff (!hresetn)
		powerdown_mode |=> !low_voltage_reset_monitor_en ##0 !lowv_fire)
		else $error("monitor active in power-down");

	a_flag_sticky: assert property (@(posedge hclk)
		disable iff (!hresetn)
		flags_r[FLAG_LOWV_BIT] && !wr_flags |=> flags_r[FLAG_LOWV_BIT])
		else $error("low-voltage flag lost without write");

	a_wdt_short_delay: assert property (@(posedge hclk)
		disable iff (!hresetn)
		wdt_full && !lowv_fire && !bad_fire[0] && !bad_fire[1] &&
		!hold_req && (state_r == ST_RUN) |=>
		timeout_status_flag && (delay_cnt_r == CNT_W'(SHORT_TICKS)) &&
		!core_reset_n)
		else $error("watchdog reset wrong delay or flag");

	a_sleep_wdt_partial: assert property (@(posedge hclk)
		disable iff (!hresetn)
		s_sleep_timeout |=> s_partial_clear)
		else $error("sleeping time-out not a partial clear");

	a_normal_wdt_pdf: assert property (@(posedge hclk)
		disable iff (!hresetn)
		wdt_full && !(wr_stat) |=>
		powerdown_status_flag == $past(powerdown_status_flag))
		else $error("normal time-out changed power-down flag");

	a_bad_wdt_flag: assert property (@(posedge hclk)
		disable iff (!hresetn)
		bad_fire[1] |=> flags_r[FLAG_BADWDT_BIT] && !core_reset_n)
		else $error("bad watchdog code flag not set");

endmodule : reset_source_manager

`default_nettype wire

// ==== reset_source_pkg.sv ====
/*
 * Constants for the reset source manager: bus map, field positions,
 * reset values, threshold codes, timing figures and the sequencer states.
 * Assumes a 100 MHz bus clock and a 32 kHz low-speed oscillator rate that
 * is made from that clock by a divider.
 */
`default_nettype none

package reset_source_pkg;

	// clock rates
	localparam int unsigned HCLK_FREQ_HZ  = 100_000_000;
	localparam int unsigned LSOSC_FREQ_HZ = 32_000;
	localparam int unsigned LSOSC_DIV_CYC = HCLK_FREQ_HZ / LSOSC_FREQ_HZ;

	// start-up delays, in microseconds as printed, then in oscillator ticks
	localparam int unsigned STARTUP_LONG_US  = 50_000;
	localparam int unsigned STARTUP_SHORT_US = 16_700;
	localparam int unsigned STARTUP_LONG_TICKS =
		(STARTUP_LONG_US * (LSOSC_FREQ_HZ / 1000) + 999) / 1000;
	localparam int unsigned STARTUP_SHORT_TICKS =
		(STARTUP_SHORT_US * (LSOSC_FREQ_HZ / 1000) + 999) / 1000;

	// low-supply filter time; a longest-ignored time, rounded down
	localparam int unsigned LOW_SUPPLY_MIN_US  = 120;
	localparam int unsigned LOW_SUPPLY_MIN_CYC =
		LOW_SUPPLY_MIN_US * (HCLK_FREQ_HZ / 1_000_000);

	// invalid code reaction: 2 to 3 oscillator periods
	localparam logic [1:0] BAD_CODE_TICKS = 2'h3;

	// counter widths
	localparam int unsigned CNT_W = 16;
	localparam int unsigned DIV_W = 12;

	// register byte offsets
	localparam logic [7:0] THRESH_OFS = 8'h00;
	localparam logic [7:0] FLAGS_OFS  = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;

	// reset cause flag bit positions
	localparam int unsigned FLAG_BADWDT_BIT = 0;
	localparam int unsigned FLAG_BADTHR_BIT = 1;
	localparam int unsigned FLAG_LOWV_BIT   = 2;
	localparam int unsigned FLAGS_W         = 3;

	// status bit positions
	localparam int unsigned STAT_TIMEOUT_BIT = 0;
	localparam int unsigned STAT_PWRDN_BIT   = 1;

	// threshold codes
	localparam logic [7:0] THR_2V10   = 8'h55;
	localparam logic [7:0] THR_2V55   = 8'h33;
	localparam logic [7:0] THR_3V15   = 8'h99;
	localparam logic [7:0] THR_3V80   = 8'haa;
	localparam logic [7:0] THRESH_POR = 8'h55;

	// sequencer states
	typedef enum logic [1:0] {
		ST_HOLD  = 2'b00,
		ST_DELAY = 2'b01,
		ST_RUN   = 2'b10
	} seq_state_e;

endpackage : reset_source_pkg

`default_nettype wire

// ==== reset_source_manager_bench.sv ====
/*
 * Self-checking bench for the reset source manager: registers over
 * AHB-Lite, reset sources, start-up delays and the cause flags.
 * Assumes the package and the design are compiled first; one slave,
 * so hready is the slave's own hreadyout.
 */
`timescale 1ns/1ps
`default_nettype none

module reset_source_manager_bench;
	import reset_source_pkg::*;

	// short counts so the delays fit a quick run
	localparam int unsigned DIV = 4;
	localparam int unsigned LT  = 8;
	localparam int unsigned ST  = 3;
	localparam int unsigned LS  = 10;
	localparam int          LLO = (LT - 1) * DIV + 1;
	localparam int          LHI = LT * DIV + 12;
	localparam int          SLO = (ST - 1) * DIV + 1;
	localparam int          SHI = ST * DIV + 8;

	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        pin_n, low_sup, wdt_to, wdt_bad, slp, idl, pdn;
	logic        core_n, pc_clr, sp_clr, io_pre, to_flag, pd_flag, mon_en;
	logic [7:0]  thr_code;
	logic [15:0] lfsr;
	logic [7:0]  codes [4] = '{8'h55, 8'h33, 8'h99, 8'haa};
	int          n_errors, n_checks;

	reset_source_manager #(.LSOSC_DIV(DIV), .LONG_TICKS(LT),
		.SHORT_TICKS(ST), .LOW_SUPPLY_CYC(LS)) u_reset_source_manager (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .external_reset_pin_n(pin_n),
		.low_supply_detect(low_sup), .watchdog_timeout(wdt_to),
		.bad_watchdog_code(wdt_bad), .sleep_mode(slp), .idle_mode(idl),
		.powerdown_mode(pdn), .core_reset_n(core_n), .pc_clear(pc_clr),
		.sp_clear(sp_clr), .io_port_preset(io_pre),
		.timeout_status_flag(to_flag), .powerdown_status_flag(pd_flag),
		.threshold_select_code(thr_code),
		.low_voltage_reset_monitor_en(mon_en));

	// single slave drives the bus ready
	assign hready = hreadyout;

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// random source and expected values
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	function automatic logic code_ok(input logic [7:0] c);
		return c == 8'h55 || c == 8'h33 || c == 8'h99 || c == 8'haa;
	endfunction : code_ok
	function automatic logic [31:0] exp_thr(input logic [7:0] c);
		return code_ok(c) ? {24'h0, c} : 32'h55;
	endfunction : exp_thr
	function automatic logic [31:0] exp_clr(input logic [31:0] o, w);
		return o & w & 32'h7;
	endfunction : exp_clr

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	task automatic hang;
		n_errors++;
		$display("mismatch at %0t: wait ran out", $time);
		conclude();
	endtask : hang

	// compares, one per kind of result
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk32
	task automatic chk1(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: bit %b want %b", $time, g, e);
		end
	endtask : chk1
	task automatic chk_rng(input int n, input int lo, input int hi);
		n_checks++;
		if (n < lo || n > hi) begin
			n_errors++;
			$display("mismatch at %0t: %0d cycles not in %0d..%0d",
				$time, n, lo, hi);
		end
	endtask : chk_rng

	// waits for ready sampled high at a rising edge
	task automatic ready_wait(output logic [31:0] d);
		logic ok;
		int   k;
		k = 0;
		ok = 1'b0;
		while (ok !== 1'b1) begin
			if (k == 40) hang();
			@(negedge hclk);
			ok = hreadyout;
			d = hrdata;
			@(posedge hclk);
			k++;
		end
	endtask : ready_wait

	task automatic bus(input logic w, input logic [31:0] a, wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		ready_wait(rd);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		ready_wait(rd);
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk32(x, e);
		chk1(hresp, 1'b0);
	endtask : rd_chk

	// counts cycles until the core reset reaches a level
	task automatic wait_core(input logic lvl, input int lo, input int hi);
		int   n;
		logic s;
		n = 0;
		s = ~lvl;
		while (s !== lvl) begin
			if (n > hi + 4) hang();
			@(negedge hclk);
			s = core_n;
			n++;
		end
		@(posedge hclk);
		chk_rng(n, lo, hi);
	endtask : wait_core
	task automatic hold_core(input int c);
		logic ok;
		ok = 1'b1;
		repeat (c) begin
			@(negedge hclk);
			ok = ok & core_n;
		end
		@(posedge hclk);
		chk1(ok, 1'b1);
	endtask : hold_core
	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done

	initial begin : main
		logic [7:0]  c;
		logic [31:0] w, a;
		hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = 32'h0; pin_n = 1'b1; low_sup = 1'b0;
		wdt_to = 1'b0; wdt_bad = 1'b0; slp = 1'b0; idl = 1'b0;
		pdn = 1'b0; hresetn = 1'b0; lfsr = 16'h44f1;
		n_errors = 0; n_checks = 0;
		// power-on: core held, ports preset, code at its default
		repeat (5) @(posedge hclk);
		chk1(core_n, 1'b0);
		chk1(io_pre, 1'b1);
		chk1(pc_clr, 1'b1);
		chk32({24'h0, thr_code}, 32'h55);
		chk1(mon_en, 1'b1);
		hresetn <= 1'b1;
		wait_core(1'b1, LLO, LHI);
		rd_chk(32'h0, 32'h55);
		rd_chk(32'h4, 32'h0);
		rd_chk(32'h8, 32'h0);
		done("power-on");
		// every valid code reads back and causes no reset
		for (int i = 0; i < 4; i++) begin
			wr(32'h0, {24'h0, codes[i]});
			rd_chk(32'h0, exp_thr(codes[i]));
			hold_core(4 * DIV);
		end
		done("valid codes");
		// random bad codes: reset in 2..3 ticks, code restored, flag set
		repeat (2) begin
			lfsr = lfsr_next(lfsr);
			c = code_ok(lfsr[7:0]) ? lfsr[7:0] ^ 8'h01 : lfsr[7:0];
			wr(32'h0, {24'h0, c});
			wait_core(1'b0, 2 * DIV - 2, 3 * DIV + 4);
			wait_core(1'b1, 1, LHI);
			rd_chk(32'h0, exp_thr(c));
			chk32({24'h0, thr_code}, 32'h55);
			wr(32'h4, 32'hffffffff);
			rd_chk(32'h4, 32'h2);
			w = {lfsr, lfsr} & ~32'h2;
			wr(32'h4, w);
			rd_chk(32'h4, exp_clr(32'h2, w));
		end
		done("bad codes");
		// low supply: a dip of the limit is ignored, a longer one resets
		wr(32'h0, 32'h99);
		low_sup <= 1'b1;
		repeat (LS) @(posedge hclk);
		low_sup <= 1'b0;
		hold_core(3 * LS);
		low_sup <= 1'b1;
		wait_core(1'b0, LS, LS + 6);
		repeat (10) @(posedge hclk);
		chk1(core_n, 1'b0);
		low_sup <= 1'b0;
		wait_core(1'b1, LLO, LHI + 3);
		rd_chk(32'h0, 32'h99);
		rd_chk(32'h4, 32'h4);
		wr(32'h4, 32'hfb);
		rd_chk(32'h4, exp_clr(32'h4, 32'hfb));
		done("low supply");
		// power-down mode switches the monitor off
		pdn <= 1'b1;
		repeat (3) @(posedge hclk);
		chk1(mon_en, 1'b0);
		low_sup <= 1'b1;
		hold_core(3 * LS);
		low_sup <= 1'b0;
		repeat (4) @(posedge hclk);
		pdn <= 1'b0;
		repeat (3) @(posedge hclk);
		chk1(mon_en, 1'b1);
		done("power-down");
		// watchdog time-out while running: full reset, short delay
		wdt_to <= 1'b1;
		@(posedge hclk);
		wdt_to <= 1'b0;
		wait_core(1'b0, 1, 3);
		chk1(io_pre, 1'b1);
		chk1(pc_clr, 1'b1);
		wait_core(1'b1, SLO, SHI);
		chk1(to_flag, 1'b1);
		rd_chk(32'h8, 32'h1);
		done("watchdog run");
		// pin low holds the core, long delay after release
		pin_n <= 1'b0;
		wait_core(1'b0, 2, 5);
		repeat (20) @(posedge hclk);
		chk1(core_n, 1'b0);
		chk1(pc_clr, 1'b1);
		chk1(sp_clr, 1'b1);
		chk1(io_pre, 1'b1);
		pin_n <= 1'b1;
		wait_core(1'b1, LLO, LHI + 3);
		rd_chk(32'h8, 32'h1);
		done("pin");
		// sleeping and idle time-outs clear only counter and stack
		for (int i = 0; i < 2; i++) begin
			wr(32'h8, 32'h0);
			slp <= (i == 0);
			idl <= (i == 1);
			wdt_to <= 1'b1;
			@(posedge hclk);
			wdt_to <= 1'b0;
			@(negedge hclk);
			chk1(pc_clr, 1'b1);
			chk1(sp_clr, 1'b1);
			chk1(core_n, 1'b1);
			chk1(io_pre, 1'b0);
			@(negedge hclk);
			chk1(pc_clr, 1'b0);
			@(posedge hclk);
			slp <= 1'b0;
			idl <= 1'b0;
			chk1(pd_flag, 1'b1);
			rd_chk(32'h8, 32'h3);
		end
		done("sleep time-out");
		// bad watchdog control code while running
		wr(32'h8, 32'h0);
		wdt_bad <= 1'b1;
		wait_core(1'b0, 2 * DIV - 2, 3 * DIV + 4);
		wdt_bad <= 1'b0;
		wait_core(1'b1, 1, LHI);
		rd_chk(32'h4, 32'h1);
		wr(32'h4, 32'h0);
		rd_chk(32'h4, 32'h0);
		done("watchdog code");
		// unmapped places read zero and leave registers alone
		repeat (3) begin
			lfsr = lfsr_next(lfsr);
			a = {14'h0, lfsr, 2'h0} | 32'h100;
			wr(a, 32'hff);
			rd_chk(a, 32'h0);
		end
		wr(32'hc, 32'h0);
		rd_chk(32'hc, 32'h0);
		rd_chk(32'h0, 32'h99);
		done("unmapped");
		conclude();
	end

endmodule : reset_source_manager_bench

`default_nettype wire
